/* File: design/rmg_top.sv */
// Link monitors (rate, lines, line length, sensor status) and seven general-purpose pins.
// Assumes receiver signals are on ref_clk; pins and link clocks arrive asynchronously.
`timescale 1ns/1ns

module rmg_top import rmg_pkg::*; #(
    parameter int WINDOW_CYC = FREQ_WINDOW_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Receive ports
    input wire logic [1:0] link_clk_in,
    input wire logic [1:0] rx_csi_mode,
    input wire logic [1:0] rx_long_packet,
    input wire logic [1:0] rx_line_valid,
    input wire logic [1:0] rx_frame_valid,
    input wire logic [1:0] rx_byte_valid,
    input wire logic [1:0] rx_lock,
    input wire logic [1:0] rx_pass,
    input wire logic [1:0][3:0] rx_remote_pin,
    input wire logic [1:0][31:0] rx_sensor_status,
    // Pins
    input wire logic [6:0] gpio_in,
    output logic [6:0] gpio_out,
    output logic [6:0] gpio_oe_n,
    output logic [6:0] gpio_in_disable,
    output logic [6:0] gpio_pd_disable,
    output logic interrupt_out_n
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [1:0] lk_s1;
        logic [1:0] lk_s2;
        logic [1:0] lk_s3;
        logic [6:0] pin_s1;
        logic [6:0] pin_s2;
        logic [15:0] win_cnt;
        logic [1:0][15:0] edge_cnt;
        logic [1:0][15:0] freq_val;
        logic [1:0] stable;
        logic [1:0] no_clk;
        logic [1:0] freq_chg;
        logic [1:0] lv_d;
        logic [1:0] fv_d;
        logic [1:0][15:0] line_cnt;
        logic [1:0][15:0] byte_cnt;
        logic [1:0][15:0] last_len;
        logic [1:0][15:0] lines_show;
        logic [1:0][15:0] len_show;
        logic [1:0] lines_frz;
        logic [1:0] len_frz;
        logic [1:0][31:0] sens_d;
        logic [1:0][3:0] rise;
        logic [1:0][3:0] fall;
        logic port_sel;
        logic [3:0] int_en;
        logic [6:0] in_dis;
        logic [6:0] pd_dis;
        logic [6:0][7:0] pin_ctl;
        logic [7:0] freq_ctl;
        logic [7:0] rdata;
        logic [6:0] pout;
        logic [6:0] poe_n;
        logic int_n;
    } rmg_state_t;

    rmg_state_t s;
    rmg_state_t next_s;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [15:0] rmg_abs_diff(input logic [15:0] a, input logic [15:0] b);
        rmg_abs_diff = (a > b) ? (a - b) : (b - a);
    endfunction : rmg_abs_diff

    function automatic logic rmg_pin_drive(
        input logic [7:0] ctl,
        input logic [1:0][3:0] rpin,
        input logic [1:0] lock,
        input logic [1:0] pass,
        input logic [1:0] fv,
        input logic [1:0] lv,
        input logic irq
    );
        logic [2:0] fsel;
        logic [2:0] src;
        logic [7:0] port_sig;
        int unsigned pi;
        fsel = ctl[CTL_SEL_LSB +: 3];
        src = ctl[CTL_SRC_LSB +: 3];
        pi = (src == SRC_PORT1) ? 1 : 0;
        port_sig = {lv[pi], fv[pi], pass[pi], lock[pi], rpin[pi]};
        rmg_pin_drive = 1'b0;
        case (src)
            SRC_PORT0: rmg_pin_drive = port_sig[fsel];
            SRC_PORT1: rmg_pin_drive = port_sig[fsel];
            SRC_DEVICE: begin
                case (fsel)
                    3'h0: rmg_pin_drive = ctl[CTL_VAL];
                    3'h1: rmg_pin_drive = |lock;
                    3'h2: rmg_pin_drive = &lock;
                    3'h3: rmg_pin_drive = &pass;
                    3'h5: rmg_pin_drive = irq;
                    3'h6: rmg_pin_drive = ~irq;
                    default: rmg_pin_drive = 1'b0;
                endcase
            end
            default: rmg_pin_drive = 1'b0;
        endcase
    endfunction : rmg_pin_drive

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    logic [1:0] rd_hit_sel;
    logic [1:0] chg_set;
    logic irq_any;
    logic [15:0] new_len;
    logic [15:0] low_thr;
    logic [15:0] hyst;
    logic win_end;

    always_comb begin
        next_s = s;
        rd_hit_sel = 2'b00;
        rd_hit_sel[s.port_sel] = 1'b1;
        chg_set = 2'b00;
        new_len = 16'h0000;
        low_thr = {12'h000, s.freq_ctl[FDC_LOW_LSB +: 4]};
        hyst = {12'h000, s.freq_ctl[FDC_HYST_LSB +: 4]};
        win_end = (s.win_cnt == 16'(WINDOW_CYC - 1));

        // Synchronisers
        next_s.lk_s1 = link_clk_in;
        next_s.lk_s2 = s.lk_s1;
        next_s.lk_s3 = s.lk_s2;
        next_s.pin_s1 = gpio_in;
        next_s.pin_s2 = s.pin_s1;

        next_s.win_cnt = win_end ? 16'h0000 : s.win_cnt + 16'h0001;

        for (int p = 0; p < 2; p++) begin
            if (win_end) begin
                next_s.edge_cnt[p] = 16'h0000;
                next_s.freq_val[p] = s.edge_cnt[p];
                next_s.no_clk[p] = (s.edge_cnt[p] < low_thr);
                if (rmg_abs_diff(s.edge_cnt[p], s.freq_val[p]) > hyst) begin
                    next_s.stable[p] = 1'b0;
                    next_s.freq_chg[p] = 1'b1;
                    chg_set[p] = 1'b1;
                end else begin
                    next_s.stable[p] = 1'b1;
                end
            end else if (s.lk_s2[p] && !s.lk_s3[p] && s.edge_cnt[p] != 16'hffff) begin
                next_s.edge_cnt[p] = s.edge_cnt[p] + 16'h0001;
            end

            next_s.lv_d[p] = rx_line_valid[p];
            next_s.fv_d[p] = rx_frame_valid[p];
            if (rx_csi_mode[p] ? rx_long_packet[p] : (rx_line_valid[p] && !s.lv_d[p])) begin
                next_s.line_cnt[p] = s.line_cnt[p] + 16'h0001;
            end
            if (rx_line_valid[p] && !s.lv_d[p]) begin
                next_s.byte_cnt[p] = {15'h0000, rx_byte_valid[p]};
            end else if (rx_byte_valid[p] && s.byte_cnt[p] != 16'hffff) begin
                next_s.byte_cnt[p] = s.byte_cnt[p] + 16'h0001;
            end
            if (!rx_line_valid[p] && s.lv_d[p]) begin
                next_s.last_len[p] = s.byte_cnt[p];
            end
            // Frame end publishes results
            if (!rx_frame_valid[p] && s.fv_d[p]) begin
                next_s.line_cnt[p] = 16'h0000;
                new_len = (!rx_line_valid[p] && s.lv_d[p]) ? s.byte_cnt[p] : s.last_len[p];
                if (!(s.int_en[IEN_LINES] && s.lines_frz[p])) begin
                    next_s.lines_show[p] = s.line_cnt[p];
                    if (s.int_en[IEN_LINES] && s.line_cnt[p] != s.lines_show[p]) begin
                        next_s.lines_frz[p] = 1'b1;
                    end
                end
                if (!(s.int_en[IEN_LEN] && s.len_frz[p])) begin
                    next_s.len_show[p] = new_len;
                    if (s.int_en[IEN_LEN] && new_len != s.len_show[p]) begin
                        next_s.len_frz[p] = 1'b1;
                    end
                end
            end

            next_s.sens_d[p] = rx_sensor_status[p];
        end

        // Register reads and their side effects
        if (reg_rd) begin
            next_s.rdata = 8'h00;
            case (reg_addr)
                OFF_PIN_LEVEL: next_s.rdata = {1'b0, s.pin_s2};
                OFF_PIN_IN_DIS: next_s.rdata = {1'b0, s.in_dis};
                OFF_PIN_PD_DIS: next_s.rdata = {1'b0, s.pd_dis};
                OFF_FREQ_CTL: next_s.rdata = s.freq_ctl;
                OFF_INT_ENABLE: next_s.rdata = {4'h0, s.int_en};
                OFF_PORT_SEL: next_s.rdata = {7'h00, s.port_sel};
                OFF_FREQ_HIGH: next_s.rdata = s.freq_val[s.port_sel][15:8];
                OFF_FREQ_LOW: next_s.rdata = s.freq_val[s.port_sel][7:0];
                OFF_PORT_STS2: begin
                    next_s.rdata = {5'h00, s.no_clk[s.port_sel], s.stable[s.port_sel],
                        s.freq_chg[s.port_sel]};
                    next_s.freq_chg = (s.freq_chg & ~rd_hit_sel) | chg_set;
                end
                OFF_LINES_HIGH: next_s.rdata = s.lines_show[s.port_sel][15:8];
                OFF_LINES_LOW: begin
                    next_s.rdata = s.lines_show[s.port_sel][7:0];
                    next_s.lines_frz = next_s.lines_frz & ~(rd_hit_sel & s.lines_frz);
                end
                OFF_LEN_HIGH: next_s.rdata = s.len_show[s.port_sel][15:8];
                OFF_LEN_LOW: begin
                    next_s.rdata = s.len_show[s.port_sel][7:0];
                    next_s.len_frz = next_s.len_frz & ~(rd_hit_sel & s.len_frz);
                end
                OFF_CAM_RISE: begin
                    next_s.rdata = {4'h0, s.rise[s.port_sel]};
                    next_s.rise[s.port_sel] = 4'h0;
                end
                OFF_CAM_FALL: begin
                    next_s.rdata = {4'h0, s.fall[s.port_sel]};
                    next_s.fall[s.port_sel] = 4'h0;
                end
                default: begin
                    if (reg_addr >= OFF_SENSOR0 && reg_addr <= OFF_SENSOR3) begin
                        next_s.rdata = s.sens_d[s.port_sel][8 * (reg_addr - OFF_SENSOR0) +: 8];
                    end else if (reg_addr >= OFF_PIN_CTL0 && reg_addr <= OFF_PIN_CTL6) begin
                        next_s.rdata = s.pin_ctl[reg_addr - OFF_PIN_CTL0];
                    end
                end
            endcase
        end

        // Sensor change events, set wins over clear
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 4; k++) begin
                if (|(rx_sensor_status[p][8 * k +: 8] & ~s.sens_d[p][8 * k +: 8])) begin
                    next_s.rise[p][k] = 1'b1;
                end
                if (|(~rx_sensor_status[p][8 * k +: 8] & s.sens_d[p][8 * k +: 8])) begin
                    next_s.fall[p][k] = 1'b1;
                end
            end
        end

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                OFF_PIN_IN_DIS: next_s.in_dis = reg_wdata[6:0];
                OFF_PIN_PD_DIS: next_s.pd_dis = reg_wdata[6:0] & ~7'h08;
                OFF_FREQ_CTL: next_s.freq_ctl = reg_wdata;
                OFF_INT_ENABLE: next_s.int_en = reg_wdata[3:0];
                OFF_PORT_SEL: next_s.port_sel = reg_wdata[0];
                default: begin
                    if (reg_addr >= OFF_PIN_CTL0 && reg_addr <= OFF_PIN_CTL6) begin
                        next_s.pin_ctl[reg_addr - OFF_PIN_CTL0] = reg_wdata;
                    end
                end
            endcase
        end

        irq_any = (|s.freq_chg && s.int_en[IEN_FREQ]) || (|s.lines_frz) || (|s.len_frz)
            || (s.int_en[IEN_SENSOR] && (|s.rise || |s.fall));
        next_s.int_n = ~irq_any;

        // output enable and value per pin
        for (int i = 0; i < 7; i++) begin
            next_s.pout[i] = rmg_pin_drive(s.pin_ctl[i], rx_remote_pin, rx_lock, rx_pass,
                rx_frame_valid, rx_line_valid, irq_any);
            next_s.poe_n[i] = ~s.pin_ctl[i][CTL_EN];
        end
        next_s.poe_n[OD_PIN] = ~(irq_any ||
            (s.pin_ctl[OD_PIN][CTL_EN] && !next_s.pout[OD_PIN]));
        next_s.pout[OD_PIN] = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.in_dis <= RST_IN_DIS;
            s.pd_dis <= RST_PD_DIS;
            s.pin_ctl <= {7{RST_CTL}};
            s.freq_ctl <= RST_FREQ_CTL;
            s.int_en <= RST_INT_EN;
            s.poe_n <= 7'h7f;
            s.int_n <= 1'b1;
            s.stable <= 2'b00;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign gpio_out = s.pout;
    assign gpio_oe_n = s.poe_n;
    assign gpio_in_disable = s.in_dis;
    assign gpio_pd_disable = s.pd_dis;
    assign interrupt_out_n = s.int_n;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking rmg_cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_window_period: assert property (win_end |=> s.win_cnt == 16'h0000 ##1 !win_end)
        else $error("window counter did not restart");
    a_absent_flag: assert property (win_end && s.edge_cnt[0] < low_thr |=> s.no_clk[0])
        else $error("absent flag not set below threshold");
    a_stable_drop: assert property (win_end && rmg_abs_diff(s.edge_cnt[0], s.freq_val[0]) > hyst
        |=> !s.stable[0] && s.freq_chg[0])
        else $error("stable not cleared on rate change");
    a_freq_irq: assert property (s.freq_chg[0] && s.int_en[IEN_FREQ] |=> !interrupt_out_n)
        else $error("rate change did not interrupt");
    a_lines_hold: assert property (s.lines_frz[0] && s.int_en[IEN_LINES]
        && !(reg_rd && reg_addr == OFF_LINES_LOW) |=> $stable(s.lines_show[0]))
        else $error("frozen line count moved");
    a_len_hold: assert property (s.len_frz[0] && s.int_en[IEN_LEN]
        && !(reg_rd && reg_addr == OFF_LEN_LOW) |=> $stable(s.len_show[0]))
        else $error("held line length moved");
    a_rise_clear: assert property (reg_rd && reg_addr == OFF_CAM_RISE && !s.port_sel
        && s.sens_d[0] == rx_sensor_status[0] |=> s.rise[0] == 4'h0)
        else $error("rise status not cleared by read");
    a_level_read: assert property (reg_rd && reg_addr == OFF_PIN_LEVEL
        |=> reg_rdata == {1'b0, $past(s.pin_s2)})
        else $error("pin level read wrong");
    a_drive_off: assert property (!s.pin_ctl[0][CTL_EN] |=> gpio_oe_n[0])
        else $error("pin drives while disabled");
    a_value_drive: assert property (s.pin_ctl[0] == 8'h13 |=> !gpio_oe_n[0] && gpio_out[0])
        else $error("register value not driven");
    a_port1_lock: assert property (s.pin_ctl[0] == 8'h85 |=> gpio_out[0] == $past(rx_lock[1]))
        else $error("port 1 lock not forwarded");
    a_od_pin: assert property (!interrupt_out_n |-> !gpio_oe_n[OD_PIN] && !gpio_out[OD_PIN])
        else $error("open drain pin not pulled by interrupt");

    c_rate_change: cover property (win_end && !s.stable[0] ##1 s.stable[0]);
    c_lines_freeze: cover property (s.lines_frz[0] ##[1:50] !s.lines_frz[0]);
    c_sensor_event: cover property (|s.rise[1] ##1 |s.fall[1]);
    c_pin_output: cover property (!gpio_oe_n[5] ##1 gpio_out[5] ##1 !gpio_out[5]);

endmodule : rmg_top

/* File: design/rmg_pkg.sv */
// Package for the link monitor and general-purpose pin block.
// Assumes a 20 MHz core clock and a byte-wide register port from the host serial core.
package rmg_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] OFF_PIN_LEVEL = 8'h0e;
    localparam logic [7:0] OFF_PIN_IN_DIS = 8'h0f;
    localparam logic [7:0] OFF_PIN_CTL0 = 8'h10;
    localparam logic [7:0] OFF_PIN_CTL6 = 8'h16;
    localparam logic [7:0] OFF_INT_ENABLE = 8'h23;
    localparam logic [7:0] OFF_FREQ_HIGH = 8'h42;
    localparam logic [7:0] OFF_FREQ_LOW = 8'h43;
    localparam logic [7:0] OFF_CAM_RISE = 8'h44;
    localparam logic [7:0] OFF_CAM_FALL = 8'h45;
    localparam logic [7:0] OFF_PORT_SEL = 8'h4c;
    localparam logic [7:0] OFF_PORT_STS2 = 8'h4e;
    localparam logic [7:0] OFF_SENSOR0 = 8'h51;
    localparam logic [7:0] OFF_SENSOR3 = 8'h54;
    localparam logic [7:0] OFF_LINES_HIGH = 8'h73;
    localparam logic [7:0] OFF_LINES_LOW = 8'h74;
    localparam logic [7:0] OFF_LEN_HIGH = 8'h75;
    localparam logic [7:0] OFF_LEN_LOW = 8'h76;
    localparam logic [7:0] OFF_FREQ_CTL = 8'h77;
    localparam logic [7:0] OFF_PIN_PD_DIS = 8'hbe;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int STS2_FREQ_CHG = 0;
    localparam int STS2_STABLE = 1;
    localparam int STS2_NO_CLK = 2;
    localparam int CTL_EN = 0;
    localparam int CTL_VAL = 1;
    localparam int CTL_SRC_LSB = 2;
    localparam int CTL_SEL_LSB = 5;
    localparam int FDC_LOW_LSB = 0;
    localparam int FDC_HYST_LSB = 4;
    localparam int IEN_FREQ = 0;
    localparam int IEN_LINES = 1;
    localparam int IEN_LEN = 2;
    localparam int IEN_SENSOR = 3;
    localparam int OD_PIN = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Source codes and reset values
    localparam logic [2:0] SRC_PORT0 = 3'h0;
    localparam logic [2:0] SRC_PORT1 = 3'h1;
    localparam logic [2:0] SRC_DEVICE = 3'h4;
    localparam logic [7:0] RST_CTL = 8'h00;
    localparam logic [6:0] RST_IN_DIS = 7'h00;
    localparam logic [6:0] RST_PD_DIS = 7'h00;
    localparam logic [7:0] RST_FREQ_CTL = 8'h21;
    localparam logic [3:0] RST_INT_EN = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int FREQ_WINDOW_NS = 500000;
    localparam int FREQ_WINDOW_CYC = FREQ_WINDOW_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        RMG_MODE_RAW = 2'b00,
        RMG_MODE_CSI = 2'b01
    } rmg_mode_t;

endpackage : rmg_pkg

/* File: bench/rmg_far_model.sv */
// Far-side model: remote serializer link clocks and video framing for both ports.
// Assumes the bench calls send_frame just after a rising edge of ref_clk.
`timescale 1ns/1ns

module rmg_far_model (
    // Core clock and control
    input wire logic ref_clk,
    input wire logic [1:0] clk_run,
    input wire logic [1:0] csi_mode,
    // Link side
    output logic [1:0] link_clk,
    output logic [1:0] long_packet,
    output logic [1:0] line_valid,
    output logic [1:0] frame_valid,
    output logic [1:0] byte_valid
);
    initial begin
        link_clk = 2'h0;
        long_packet = 2'h0;
        line_valid = 2'h0;
        frame_valid = 2'h0;
        byte_valid = 2'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link clocks stand still while stopped
    always #65 link_clk[0] = clk_run[0] ? ~link_clk[0] : 1'b0;
    always #85 link_clk[1] = clk_run[1] ? ~link_clk[1] : 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // packet or line-valid per line
    task automatic send_frame(input int p, input int n, input int len, input int last);
        int b;
        @(posedge ref_clk) #1;
        frame_valid[p] = 1'b1;
        for (int i = 0; i < n; i++) begin
            b = (i == n - 1) ? last : len;
            @(posedge ref_clk) #1;
            line_valid[p] = !csi_mode[p];
            long_packet[p] = csi_mode[p];
            repeat (b) begin
                @(posedge ref_clk) #1;
                long_packet[p] = 1'b0;
                byte_valid[p] = 1'b1;
            end
            @(posedge ref_clk) #1;
            line_valid[p] = 1'b0;
            byte_valid[p] = 1'b0;
        end
        @(posedge ref_clk) #1;
        frame_valid[p] = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask : send_frame
endmodule : rmg_far_model

/* File: bench/tb_top.sv */
// Bench for the monitor and pin block: register tasks, far-side model and pad levels.
// Assumes a 20 MHz core clock and the byte-wide register port of the design.
`timescale 1ns/1ns

module tb_top import rmg_pkg::*;;
    logic ref_clk;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [1:0] clk_run = 2'h0;
    logic [1:0] csi = 2'h0;
    logic [1:0] lock = 2'h1;
    logic [1:0] pass = 2'h2;
    logic [1:0] lclk, lp, lv, fv, bv;
    logic [1:0][3:0] rpin = {4'h5, 4'ha};
    logic [1:0][31:0] sens = {32'h0, 32'h44332211};
    logic [6:0] ext = 7'h00;
    logic [6:0] pad, gout, goe_n, gin_dis, gpd_dis;
    logic irq_n;
    int err_count = 0;
    int num_checks = 0;

    // Pad level from every driver of the pin
    assign pad = (ext & goe_n) | (gout & ~goe_n);

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    rmg_top #(.WINDOW_CYC(20)) dut (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .link_clk_in(lclk), .rx_csi_mode(csi),
        .rx_long_packet(lp), .rx_line_valid(lv), .rx_frame_valid(fv), .rx_byte_valid(bv),
        .rx_lock(lock), .rx_pass(pass), .rx_remote_pin(rpin), .rx_sensor_status(sens),
        .gpio_in(pad), .gpio_out(gout), .gpio_oe_n(goe_n), .gpio_in_disable(gin_dis),
        .gpio_pd_disable(gpd_dis), .interrupt_out_n(irq_n)
    );

    rmg_far_model far (
        .ref_clk(ref_clk), .clk_run(clk_run), .csi_mode(csi), .link_clk(lclk),
        .long_packet(lp), .line_valid(lv), .frame_valid(fv), .byte_valid(bv)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checking and register access
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk) #1;
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
        @(posedge ref_clk) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk) #1;
        reg_rd = 1'b0;
        chk(reg_rdata & m, e);
    endtask : rd

    function automatic logic sel_exp(input int s, input int f);
        logic [7:0] v;
        v = {lv[s], fv[s], pass[s], lock[s], rpin[s]};
        return v[f];
    endfunction : sel_exp

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        #3000000;
        err_count++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        #1 rst = 1'b0;
        chk({goe_n, gin_dis}, 14'h3f80);
        chk({gpd_dis, irq_n}, 8'h01);
        rd(OFF_PIN_IN_DIS, 8'h00);
        rd(OFF_PIN_PD_DIS, 8'h00);
        for (int a = 16; a < 23; a++) rd(8'(a), 8'h00);
        rd(OFF_FREQ_CTL, 8'h21);
        rd(8'h30, 8'h00);
        wr(OFF_PIN_IN_DIS, 8'h06);
        chk(gin_dis, 7'h06);
        wr(OFF_PIN_PD_DIS, 8'h7f);
        chk(gpd_dis, 7'h77);
        wr(OFF_PIN_IN_DIS, 8'h01);
        for (int s = 0; s < 2; s++) begin
            for (int f = 0; f < 8; f++) begin
                wr(OFF_PIN_CTL0, {f[2:0], s[2:0], 2'b01});
                @(posedge ref_clk) #1;
                chk({goe_n[0], gout[0]}, {1'b0, sel_exp(s, f)});
            end
        end
        for (int f = 1; f < 4; f++) begin
            wr(OFF_PIN_CTL0, {f[2:0], SRC_DEVICE, 2'b01});
            @(posedge ref_clk) #1;
            chk(gout[0], f == 1);
        end
        for (int v = 0; v < 2; v++) begin
            wr(OFF_PIN_CTL0, {3'h0, SRC_DEVICE, v[0], 1'b1});
            @(posedge ref_clk) #1;
            chk(gout[0], v[0]);
        end
        rd(OFF_PIN_CTL0, 8'h13);
        ext = 7'h54;
        wr(OFF_PIN_LEVEL, 8'hff);
        rd(OFF_PIN_LEVEL, 8'h55);
        wr(OFF_PIN_CTL0, 8'h12);
        @(posedge ref_clk) #1;
        chk(goe_n[0], 1'b1);
        for (int k = 0; k < 4; k++) rd(OFF_SENSOR0 + 8'(k), 8'(8'h11 * (k + 1)));
        rd(OFF_CAM_RISE, 8'h0f);
        wr(OFF_INT_ENABLE, 8'h08);
        sens[0][1] = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        chk({irq_n, goe_n[3]}, 2'b00);
        rd(OFF_CAM_RISE, 8'h01);
        rd(OFF_CAM_FALL, 8'h00);
        chk(irq_n, 1'b1);
        wr(OFF_INT_ENABLE, 8'h00);
        far.send_frame(0, 5, 2, 300);
        rd(OFF_LINES_HIGH, 8'h00);
        rd(OFF_LINES_LOW, 8'h05);
        rd(OFF_LEN_HIGH, 8'h01);
        rd(OFF_LEN_LOW, 8'h2c);
        csi = 2'h1;
        far.send_frame(0, 4, 2, 2);
        rd(OFF_LINES_LOW, 8'h04);
        csi = 2'h0;
        wr(OFF_INT_ENABLE, 8'h02);
        far.send_frame(0, 3, 2, 2);
        chk(irq_n, 1'b0);
        far.send_frame(0, 6, 2, 2);
        rd(OFF_LINES_HIGH, 8'h00);
        rd(OFF_LINES_LOW, 8'h03);
        @(posedge ref_clk) #1;
        chk(irq_n, 1'b1);
        wr(OFF_INT_ENABLE, 8'h04);
        far.send_frame(0, 2, 2, 7);
        far.send_frame(0, 2, 2, 9);
        rd(OFF_LEN_HIGH, 8'h00);
        rd(OFF_LEN_LOW, 8'h07);
        wr(OFF_INT_ENABLE, 8'h00);
        clk_run = 2'h1;
        repeat (60) @(posedge ref_clk);
        rd(OFF_PORT_STS2, 8'h00, 8'h04);
        repeat (45) @(posedge ref_clk);
        rd(OFF_PORT_STS2, 8'h02, 8'h07);
        rd(OFF_FREQ_HIGH, 8'h00);
        rd(OFF_FREQ_LOW, 8'h00, 8'hf0);
        wr(OFF_FREQ_CTL, 8'h2f);
        repeat (45) @(posedge ref_clk);
        rd(OFF_PORT_STS2, 8'h04, 8'h04);
        wr(OFF_FREQ_CTL, 8'h21);
        wr(OFF_INT_ENABLE, 8'h01);
        clk_run = 2'h0;
        repeat (45) @(posedge ref_clk);
        #1;
        chk(irq_n, 1'b0);
        rd(OFF_PORT_STS2, 8'h05, 8'h05);
        summarize();
    end
endmodule : tb_top
